// [rtl/xmb_params.svh]
`ifndef XMB_PARAMS_SVH
`define XMB_PARAMS_SVH

// phase lengths of one external bus cycle, in clk_sys_i cycles
`define XMB_ADDR_CYCLES 4'h2
`define XMB_LATCH_CYCLES 4'h1
`define XMB_HOLD_CYCLES 4'h1
`define XMB_STROBE_CYCLES 4'h3
`define XMB_RECOVER_CYCLES 4'h1
// reset values of the pins
`define XMB_PORT0_RESET 8'hFF
`define XMB_PORT2_RESET 8'hFF

`endif

// [rtl/xmb_pkg.sv]
package xmb_pkg;

    // kind of external access
    typedef enum logic [1:0] {
        XMB_OP_READ = 2'b00,
        XMB_OP_WRITE = 2'b01,
        XMB_OP_FETCH = 2'b10,
        XMB_OP_IDE = 2'b11
    } xmb_op_t;

    typedef struct packed {
        xmb_op_t op;
        logic ide_write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } xmb_req_t;

    typedef struct packed {
        logic [15:0] rdata;
        logic done;
    } xmb_rsp_t;

    typedef enum logic [2:0] {
        XMB_ST_IDLE = 3'b000,
        XMB_ST_ADDR = 3'b001,
        XMB_ST_HOLD = 3'b010,
        XMB_ST_STROBE = 3'b011,
        XMB_ST_RECOVER = 3'b100
    } xmb_state_t;

endpackage

// [rtl/xmb_phase_timer.sv]
`timescale 1ns/1ns
// down counter that marks the last cycle of a bus phase
module xmb_phase_timer #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // control
    input wire logic load_i,
    input wire logic [WIDTH-1:0] count_i,
    // status
    output logic last_o
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;
    wire busy = (cnt_q != '0);

    assign cnt_d = load_i ? count_i : (busy ? cnt_q - WIDTH'(1) : cnt_q);
    assign last_o = (cnt_q == WIDTH'(1));

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule // xmb_phase_timer

// [rtl/xmb_port.sv]
`timescale 1ns/1ns
`include "xmb_params.svh"
// Function
// - The latch strobe goes high at the start of every bus cycle while the low address byte is on the shared lines.
// - The low address byte and the data byte share the same eight two-way lines for memory and IDE accesses.
// - The upper address byte of a memory access is driven on eight lines that otherwise act as a general port.
// - In IDE accesses the upper lines carry a multiplexed high address and data byte for a sixteen-bit bus.
// - The read strobe is asserted for external data memory reads, code fetches and IDE reads, and is shared with port 3 bit 7.
// - The write strobe is asserted for external data memory writes and IDE writes, and is shared with port 3 bit 6.
module xmb_port (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // core request side
    input wire logic req_valid_i,
    input wire xmb_pkg::xmb_req_t req_i,
    output logic req_ready_o,
    output xmb_pkg::xmb_rsp_t rsp_o,
    // general port use of the upper lines and strobe pins
    input wire logic [7:0] port2_out_i,
    input wire logic [1:0] port3_hi_out_i,
    // straps
    input wire logic ext_code_fetch_sel_n_i,
    input wire logic boot_loader_select_i,
    output logic ext_code_only_o,
    output logic boot_to_loader_o,
    // external pins
    input wire logic [7:0] low_addr_data_bus_i,
    output logic [7:0] low_addr_data_bus_o,
    output logic low_addr_data_bus_oe_o,
    input wire logic [7:0] high_addr_bus_i,
    output logic [7:0] high_addr_bus_o,
    output logic high_addr_bus_oe_o,
    output logic addr_latch_o,
    output logic rd_n_o,
    output logic wr_n_o
);
    xmb_pkg::xmb_state_t state_q;
    xmb_pkg::xmb_state_t state_d;
    xmb_pkg::xmb_req_t cur_q;
    logic [15:0] rdata_q;
    logic done_q;
    logic [7:0] p0_q;
    logic p0_oe_q;
    logic [7:0] p2_q;
    logic p2_oe_q;
    logic ale_q;
    logic strap_done_q;
    logic ext_code_q;
    logic boot_q;
    logic load;
    logic [3:0] load_count;
    logic phase_last;
    logic latch_last;

    wire idle = (state_q == xmb_pkg::XMB_ST_IDLE);
    wire take = idle && req_valid_i;
    wire is_ide = (cur_q.op == xmb_pkg::XMB_OP_IDE);
    // code fetch reads through the read strobe as well
    wire is_read = (cur_q.op == xmb_pkg::XMB_OP_READ) || (cur_q.op == xmb_pkg::XMB_OP_FETCH)
        || (is_ide && !cur_q.ide_write);
    wire in_strobe = (state_q == xmb_pkg::XMB_ST_STROBE);
    wire in_addr = (state_q == xmb_pkg::XMB_ST_ADDR);

    // next state: address+latch, hold, strobe, recover
    always_comb begin
        state_d = state_q;
        load = 1'b0;
        load_count = 4'h0;
        unique case (state_q)
            xmb_pkg::XMB_ST_IDLE: begin
                if (req_valid_i) begin
                    state_d = xmb_pkg::XMB_ST_ADDR;
                    load = 1'b1;
                    load_count = `XMB_ADDR_CYCLES;
                end
            end
            xmb_pkg::XMB_ST_ADDR: begin
                if (phase_last) begin
                    state_d = xmb_pkg::XMB_ST_HOLD;
                    load = 1'b1;
                    load_count = `XMB_HOLD_CYCLES;
                end
            end
            xmb_pkg::XMB_ST_HOLD: begin
                if (phase_last) begin
                    state_d = xmb_pkg::XMB_ST_STROBE;
                    load = 1'b1;
                    load_count = `XMB_STROBE_CYCLES;
                end
            end
            xmb_pkg::XMB_ST_STROBE: begin
                if (phase_last) begin
                    state_d = xmb_pkg::XMB_ST_RECOVER;
                    load = 1'b1;
                    load_count = `XMB_RECOVER_CYCLES;
                end
            end
            xmb_pkg::XMB_ST_RECOVER: begin
                if (phase_last) begin
                    state_d = xmb_pkg::XMB_ST_IDLE;
                end
            end
            default: begin
                state_d = xmb_pkg::XMB_ST_IDLE;
            end
        endcase
    end

    xmb_phase_timer #(
        .WIDTH(4)
    ) u_timer (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .load_i(load),
        .count_i(load_count),
        .last_o(phase_last)
    );

    // second timer spans only the latch pulse, so the address stays on the lines after the latch strobe falls
    xmb_phase_timer #(
        .WIDTH(4)
    ) u_latch_timer (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .load_i(take),
        .count_i(`XMB_LATCH_CYCLES),
        .last_o(latch_last)
    );

    // latch strobe high for the first cycles of the address phase
    wire ale_d = take ? (`XMB_LATCH_CYCLES != 4'h0) : (ale_q && in_addr && !latch_last);
    wire strobe_next = (state_d == xmb_pkg::XMB_ST_STROBE);
    wire rd_n_d = !(strobe_next && is_read);
    // write only when not reading, so the two never overlap
    wire wr_n_d = !(strobe_next && !is_read);
    wire drive_data = strobe_next && !is_read;
    // switch to data on the edge that leaves the address phase, so a write shows data in every strobe cycle
    wire addr_next = (state_d == xmb_pkg::XMB_ST_ADDR);
    wire [7:0] p0_d = take ? req_i.addr[7:0] : (addr_next ? cur_q.addr[7:0] : cur_q.wdata[7:0]);
    wire p0_oe_d = take || (state_d == xmb_pkg::XMB_ST_ADDR) || drive_data;
    wire [7:0] hi_addr = take ? req_i.addr[15:8] : cur_q.addr[15:8];
    // the upper lines carry IDE data for exactly the strobe cycles, the address before and after
    wire ide_data_hi = is_ide && strobe_next;
    wire [7:0] p2_d = (state_d == xmb_pkg::XMB_ST_IDLE) ? port2_out_i
        : (ide_data_hi ? cur_q.wdata[15:8] : hi_addr);
    // only an IDE read releases the upper lines, for the whole strobe so the device never meets our drivers
    wire p2_oe_d = !(ide_data_hi && is_read);
    // read data is taken on the last strobe cycle, while the device still drives the lines
    wire sample = in_strobe && phase_last;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_q <= xmb_pkg::XMB_ST_IDLE;
            cur_q <= '0;
            rdata_q <= 16'h0000;
            done_q <= 1'b0;
            ale_q <= 1'b0;
            p0_q <= `XMB_PORT0_RESET;
            p0_oe_q <= 1'b0;
            p2_q <= `XMB_PORT2_RESET;
            p2_oe_q <= 1'b1;
        end else begin
            state_q <= state_d;
            if (take) begin
                cur_q <= req_i;
            end
            if (sample && is_read) begin
                rdata_q <= {is_ide ? high_addr_bus_i : 8'h00, low_addr_data_bus_i};
            end
            done_q <= sample;
            ale_q <= ale_d;
            p0_q <= p0_d;
            p0_oe_q <= p0_oe_d;
            p2_q <= p2_d;
            p2_oe_q <= p2_oe_d;
        end
    end

    // straps are caught on the first clock after reset is released
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            strap_done_q <= 1'b0;
            ext_code_q <= 1'b0;
            boot_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            ext_code_q <= !ext_code_fetch_sel_n_i;
            boot_q <= !boot_loader_select_i;
        end
    end

    // strobe pins fall back to port 3 when no cycle runs
    logic rd_pin_q;
    logic wr_pin_q;
    logic ready_q;
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            rd_pin_q <= 1'b1;
            wr_pin_q <= 1'b1;
            ready_q <= 1'b0;
        end else begin
            rd_pin_q <= (state_d == xmb_pkg::XMB_ST_IDLE) ? port3_hi_out_i[1] : rd_n_d;
            wr_pin_q <= (state_d == xmb_pkg::XMB_ST_IDLE) ? port3_hi_out_i[0] : wr_n_d;
            ready_q <= (state_d == xmb_pkg::XMB_ST_IDLE);
        end
    end

    assign req_ready_o = ready_q;
    assign rsp_o = '{rdata: rdata_q, done: done_q};
    assign ext_code_only_o = ext_code_q;
    assign boot_to_loader_o = boot_q;
    assign low_addr_data_bus_o = p0_q;
    assign low_addr_data_bus_oe_o = p0_oe_q;
    assign high_addr_bus_o = p2_q;
    assign high_addr_bus_oe_o = p2_oe_q;
    assign addr_latch_o = ale_q;
    assign rd_n_o = rd_pin_q;
    assign wr_n_o = wr_pin_q;
endmodule // xmb_port

// [tb/xmb_port_chk.sv]
`timescale 1ns/1ns
module xmb_port_chk (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // core side
    input wire logic req_valid_i,
    input wire xmb_pkg::xmb_req_t req_i,
    input wire logic req_ready_o,
    input wire xmb_pkg::xmb_rsp_t rsp_o,
    // pins
    input wire logic [7:0] low_addr_data_bus_o,
    input wire logic low_addr_data_bus_oe_o,
    input wire logic [7:0] high_addr_bus_o,
    input wire logic high_addr_bus_oe_o,
    input wire logic addr_latch_o,
    input wire logic rd_n_o,
    input wire logic wr_n_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    wire take = req_valid_i && req_ready_o;
    sequence low3(s);
        !s [*3] ##1 s;
    endsequence
    addr_latch_a: assert property (take |=> addr_latch_o && low_addr_data_bus_oe_o
        && low_addr_data_bus_o == $past(req_i.addr[7:0])) else $error("latch phase lacks low address");
    high_addr_a: assert property (take |=> high_addr_bus_oe_o
        && high_addr_bus_o == $past(req_i.addr[15:8])) else $error("upper lines lack high address");
    strobe_excl_a: assert property (!(!rd_n_o && !wr_n_o)) else $error("both strobes low");
    read_len_a: assert property ($fell(rd_n_o) |-> low3(rd_n_o)) else $error("read strobe length");
    write_len_a: assert property ($fell(wr_n_o) |-> low3(wr_n_o)) else $error("write strobe length");
    read_bus_a: assert property (!rd_n_o |-> !low_addr_data_bus_oe_o) else $error("driving during read");
    write_bus_a: assert property (!wr_n_o |-> low_addr_data_bus_oe_o) else $error("no write data");
    latch_quiet_a: assert property (addr_latch_o |-> rd_n_o && wr_n_o) else $error("strobe with latch");
    done_time_a: assert property (take |-> ##[5:12] rsp_o.done) else $error("no completion");
    write_hold_a: assert property (!wr_n_o && !$past(wr_n_o) |-> $stable(low_addr_data_bus_o)
        && $stable(high_addr_bus_o)) else $error("write data moved during strobe");
    latch_hold_a: assert property ($fell(addr_latch_o) |-> low_addr_data_bus_oe_o
        && $stable(low_addr_data_bus_o)) else $error("address gone as latch closes");
endmodule // xmb_port_chk

// [tb/xmb_mem_model.sv]
`timescale 1ns/1ns
module xmb_mem_model (
    // board side of the pins
    input wire logic clk_sys_i,
    input wire logic [7:0] lo_i,
    input wire logic [7:0] hi_i,
    input wire logic ale_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    // model drive
    output logic [7:0] lo_o,
    output logic [7:0] hi_o
);
    logic [7:0] lat_q = 8'h00;
    logic [7:0] hadr_q = 8'h00;
    logic [7:0] lo_q = 8'h00;
    logic [7:0] hi_q = 8'h00;
    logic [15:0] mem [0:65535];
    wire [15:0] key = {hadr_q, lat_q};
    // released lines toggle so a stale value never reads as good data
    assign lo_o = rd_n_i ? ~lo_q : mem[key][7:0];
    assign hi_o = rd_n_i ? ~hi_q : mem[key][15:8];
    always @(posedge clk_sys_i) begin
        lo_q <= lo_o;
        hi_q <= hi_o;
        if (ale_i) begin
            lat_q <= lo_i;
            hadr_q <= hi_i;
        end
        if (!wr_n_i) mem[key] <= {hi_i, lo_i};
    end
endmodule // xmb_mem_model

// [tb/testbench.sv]
`timescale 1ns/1ns
module testbench;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic req_valid_i = 1'b0;
    xmb_pkg::xmb_req_t req_i = '0;
    logic fetch_n = 1'b1;
    logic boot_n = 1'b1;
    logic ready, code_only, to_loader, lo_oe, hi_oe, ale, rd_n, wr_n;
    xmb_pkg::xmb_rsp_t rsp_o;
    logic [7:0] lo_dut, hi_dut, lo_mod, hi_mod;
    wire [7:0] lo_bus = lo_oe ? lo_dut : lo_mod;
    wire [7:0] hi_bus = hi_oe ? hi_dut : hi_mod;
    int errors = 0;
    int samples_checked = 0;
    logic [15:0] rd;
    always #5 clk_sys_i = ~clk_sys_i;
    xmb_port xmb_port_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .req_ready_o(ready), .rsp_o(rsp_o), .port2_out_i(8'h5A), .port3_hi_out_i(2'b11),
        .ext_code_fetch_sel_n_i(fetch_n), .boot_loader_select_i(boot_n), .ext_code_only_o(code_only),
        .boot_to_loader_o(to_loader), .low_addr_data_bus_i(lo_bus), .low_addr_data_bus_o(lo_dut),
        .low_addr_data_bus_oe_o(lo_oe), .high_addr_bus_i(hi_bus), .high_addr_bus_o(hi_dut),
        .high_addr_bus_oe_o(hi_oe), .addr_latch_o(ale), .rd_n_o(rd_n), .wr_n_o(wr_n));
    xmb_mem_model xmb_mem_model_i (.clk_sys_i(clk_sys_i), .lo_i(lo_bus), .hi_i(hi_bus), .ale_i(ale),
        .rd_n_i(rd_n), .wr_n_i(wr_n), .lo_o(lo_mod), .hi_o(hi_mod));
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task do_reset(input logic f, input logic b);
        @(negedge clk_sys_i);
        reset_i = 1'b1;
        fetch_n = f;
        boot_n = b;
        repeat (10) @(negedge clk_sys_i);
        reset_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
    endtask
    task op(input logic [1:0] o, input logic w, input logic [15:0] a, input logic [15:0] d);
        int n;
        @(negedge clk_sys_i);
        req_valid_i = 1'b1;
        req_i = '{xmb_pkg::xmb_op_t'(o), w, a, d};
        for (n = 0; ready !== 1'b1 && n < 20; n++) @(negedge clk_sys_i);
        chk(16'(ready), 16'h0001);
        @(negedge clk_sys_i);
        req_valid_i = 1'b0;
        for (n = 0; rsp_o.done !== 1'b1 && n < 20; n++) @(negedge clk_sys_i);
        chk(16'(rsp_o.done), 16'h0001);
        rd = rsp_o.rdata;
    endtask
    task t_straps;
        do_reset(1'b0, 1'b1);
        chk(16'({code_only, to_loader}), 16'h0002);
        chk(16'({hi_oe, hi_dut}), 16'h015A);
        do_reset(1'b1, 1'b0);
        chk(16'({code_only, to_loader}), 16'h0001);
    endtask
    task t_data;
        // back-to-back writes, then reads in reverse order
        op(2'h1, 1'b0, 16'h12A5, 16'h003C);
        op(2'h1, 1'b0, 16'hFE5A, 16'h00C7);
        chk(16'(xmb_mem_model_i.mem[16'h12A5][7:0]), 16'h003C);
        op(2'h0, 1'b0, 16'hFE5A, 16'h0000);
        chk(rd, 16'h00C7);
        op(2'h0, 1'b0, 16'h12A5, 16'h0000);
        chk(rd, 16'h003C);
    endtask
    task t_fetch;
        xmb_mem_model_i.mem[16'hFFFF] = 16'h0096;
        xmb_mem_model_i.mem[16'h0000] = 16'h0069;
        op(2'h2, 1'b0, 16'hFFFF, 16'h0000);
        chk(rd, 16'h0096);
        op(2'h2, 1'b0, 16'h0000, 16'h0000);
        chk(rd, 16'h0069);
    endtask
    task t_ide;
        op(2'h3, 1'b1, 16'h0107, 16'hBEEF);
        chk(xmb_mem_model_i.mem[16'h0107], 16'hBEEF);
        xmb_mem_model_i.mem[16'h0208] = 16'h4D21;
        op(2'h3, 1'b0, 16'h0208, 16'h0000);
        chk(rd, 16'h4D21);
    endtask
    initial begin
        t_straps;
        t_data;
        t_fetch;
        t_ide;
        wrap_up;
    end
    initial begin
        #20000;
        errors++;
        wrap_up;
    end
endmodule // testbench
bind xmb_port xmb_port_chk xmb_port_chk_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .rsp_o(rsp_o), .low_addr_data_bus_o(low_addr_data_bus_o),
    .low_addr_data_bus_oe_o(low_addr_data_bus_oe_o), .high_addr_bus_o(high_addr_bus_o),
    .high_addr_bus_oe_o(high_addr_bus_oe_o), .addr_latch_o(addr_latch_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o));
